// *** shared/cbm_pkg.sv ***
/*
  Shared constants for the bus master handshake block: widths, state codes
  and the fixed cycle counts of a bus transaction.
  Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
package cbm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Timing counts, in clock states of one transaction
  // ----------------------------------------------------------------
  localparam logic [3:0] CYCLE_START_LEN = 4'h2; // cycle-initiate width
  localparam logic [3:0] SYNC_SAMPLE_ST  = 4'h5; // ready sampled here
  localparam int         SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Reset values of the strobes and pulses
  // ----------------------------------------------------------------
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic PULSE_IDLE  = 1'b0;

  // ----------------------------------------------------------------
  // Transaction states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBM_IDLE  = 3'b000,
    CBM_ADDR  = 3'b001,
    CBM_DATA  = 3'b010,
    CBM_TERM  = 3'b011,
    CBM_END   = 3'b100
  } cbm_state_e;

endpackage : cbm_pkg

// *** verilog/cbm_sync2.sv ***
/*
  Two-stage synchroniser for one level that arrives from outside the clock
  domain. Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cbm_sync2
  import cbm_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : cbm_sync2

`default_nettype wire

// *** verilog/cbm_bus_master.sv ***
/*
  External bus master handshake of a 32-bit processor: address and data
  strobes, cycle-initiate pulse, data-ready, wait states via asynchronous
  acknowledge or synchronous ready, shadow override and coprocessor done.
  Assumes the core raises req for one cycle with the access fields stable,
  and that the testbench resolves the tri-state data wires.
*/
`timescale 1ns/1ps
`default_nettype none

module cbm_bus_master
  import cbm_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  // Core side
  input  wire logic          req,
  input  wire logic          req_write,
  input  wire logic          req_interlock,
  input  wire logic          req_virtual,
  input  wire logic          req_copro,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               busy,
  output logic [DW-1:0]      rdata,
  output logic               done_pulse,
  output logic               error_pulse,
  output logic               copro_done,
  // Bus side
  output logic [AW-1:0]      addr_out,
  output logic               addr_oe_n,
  output logic               addr_strobe_n,
  output logic               virtual_addr_flag,
  output logic               read_write,
  output logic               data_strobe_n,
  output logic [DW-1:0]      data_out,
  output logic               data_oe_n,
  input  wire logic [DW-1:0] data_in,
  output logic               bus_cycle_start,
  output logic               transfer_complete,
  input  wire logic          async_transfer_ack,
  input  wire logic          sync_ready_in,
  input  wire logic          shadow_bus_hold,
  input  wire logic          fault_in,
  input  wire logic          retry_in,
  input  wire logic          relinquish_retry_req,
  input  wire logic          copro_done_in
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic ack_n_s;
  logic rdy_n_s;
  logic shad_s;
  logic flt_s;
  logic rty_s;
  logic rrq_s;
  logic cdn_s;

  cbm_sync2 #(.RESET_VAL(1'b1)) u_ack (
    .clk      (clk),
    .reset    (reset),
    .async_in (async_transfer_ack),
    .sync_out (ack_n_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b1)) u_rdy (
    .clk      (clk),
    .reset    (reset),
    .async_in (sync_ready_in),
    .sync_out (rdy_n_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b0)) u_shad (
    .clk      (clk),
    .reset    (reset),
    .async_in (shadow_bus_hold),
    .sync_out (shad_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b0)) u_flt (
    .clk      (clk),
    .reset    (reset),
    .async_in (fault_in),
    .sync_out (flt_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b0)) u_rty (
    .clk      (clk),
    .reset    (reset),
    .async_in (retry_in),
    .sync_out (rty_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b0)) u_rrq (
    .clk      (clk),
    .reset    (reset),
    .async_in (relinquish_retry_req),
    .sync_out (rrq_s)
  );
  cbm_sync2 #(.RESET_VAL(1'b0)) u_cdn (
    .clk      (clk),
    .reset    (reset),
    .async_in (copro_done_in),
    .sync_out (cdn_s)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbm_state_e      state_r, state_nxt;
  logic [3:0]      clk_state_r;
  logic            write_r;
  logic            lock_r;
  logic            lock_wr_r;
  logic            virt_r;
  logic            copro_r;
  logic            shad_seen_r;
  logic            exc_r;
  logic            ack_prev_r;
  logic            rdy_hit_r;
  logic [AW-1:0]   addr_r;
  logic [DW-1:0]   wdata_r;
  logic [DW-1:0]   rdata_r;
  logic            cyc_r;
  logic            as_n_r;
  logic            ds_n_r;
  logic            aoe_n_r;
  logic            doe_n_r;
  logic            transfer_complete_r;
  logic            done_r;
  logic            err_r;
  logic            cdone_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire ack_ok      = !ack_n_s && !shad_s;
  wire at_sample   = (clk_state_r == SYNC_SAMPLE_ST);
  wire rdy_ok      = at_sample && !rdy_n_s && !shad_seen_r
                     && !shad_s;
  wire terminate   = (state_r == CBM_DATA)
                     && (ack_ok || rdy_ok || rdy_hit_r);
  wire exc_now     = flt_s || rty_s || rrq_s;
  wire start       = (state_r == CBM_IDLE) && req;
  wire relock      = (state_r == CBM_END) && lock_r && !lock_wr_r
                     && !exc_r;
  wire new_cycle   = start || relock;
  wire cyc_nxt     = new_cycle ||
                     (cyc_r && clk_state_r < CYCLE_START_LEN);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CBM_IDLE: begin
        if (req) begin
          state_nxt = CBM_ADDR;
        end
      end
      CBM_ADDR: begin
        state_nxt = CBM_DATA;
      end
      CBM_DATA: begin
        if (terminate) begin
          state_nxt = CBM_TERM;
        end
      end
      CBM_TERM: begin
        state_nxt = CBM_END;
      end
      CBM_END: begin
        state_nxt = relock ? CBM_ADDR : CBM_IDLE;
      end
      default: begin
        state_nxt = CBM_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Transaction bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r     <= CBM_IDLE;
      clk_state_r <= 4'h0;
      write_r     <= 1'b0;
      lock_r      <= 1'b0;
      lock_wr_r   <= 1'b0;
      virt_r      <= 1'b0;
      copro_r     <= 1'b0;
      shad_seen_r <= 1'b0;
      exc_r       <= 1'b0;
      ack_prev_r  <= 1'b0;
      rdy_hit_r   <= 1'b0;
      addr_r      <= '0;
      wdata_r     <= '0;
      rdata_r     <= '0;
    end else begin
      state_r    <= state_nxt;
      ack_prev_r <= ack_ok;
      if (new_cycle) begin
        clk_state_r <= 4'h1;
        shad_seen_r <= 1'b0;
        exc_r       <= 1'b0;
        rdy_hit_r   <= 1'b0;
      end else if (clk_state_r != 4'hf && state_r != CBM_IDLE) begin
        clk_state_r <= clk_state_r + 4'h1;
      end
      if (shad_s) begin
        shad_seen_r <= 1'b1;
      end
      if (exc_now && state_r != CBM_IDLE) begin
        exc_r <= 1'b1;
      end
      if (rdy_ok && !ack_prev_r) begin
        rdy_hit_r <= 1'b1;
      end
      if (start) begin
        write_r   <= req_write;
        lock_r    <= req_interlock;
        lock_wr_r <= 1'b0;
        virt_r    <= req_virtual;
        copro_r   <= req_copro;
        addr_r    <= req_addr;
        wdata_r   <= req_wdata;
      end else if (relock) begin
        write_r   <= 1'b1;
        lock_wr_r <= 1'b1;
      end
      if (terminate && !write_r) begin
        rdata_r <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus pins, all from flip-flops except virtual_addr_flag, an AND of two flip-flops, and read_write, an inverted flip-flop
  // ----------------------------------------------------------------
  wire in_xfer  = (state_nxt == CBM_ADDR) || (state_nxt == CBM_DATA)
                  || (state_nxt == CBM_TERM);
  wire as_nxt   = !((state_nxt == CBM_DATA) || (state_nxt == CBM_TERM));
  // Data strobe only once the write data has stood a cycle
  wire ds_nxt   = !((state_nxt == CBM_DATA) || (state_nxt == CBM_TERM));
  wire aoe_nxt  = !(in_xfer && !(virt_r && state_r == CBM_DATA));
  wire doe_nxt  = !(in_xfer && (relock || (start ? req_write : write_r)));

  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_r   <= PULSE_IDLE;
      as_n_r  <= STROBE_IDLE;
      ds_n_r  <= STROBE_IDLE;
      aoe_n_r <= 1'b1;
      doe_n_r <= 1'b1;
      transfer_complete_r  <= PULSE_IDLE;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      cdone_r <= 1'b0;
    end else begin
      cyc_r   <= cyc_nxt;
      as_n_r  <= as_nxt;
      ds_n_r  <= ds_nxt;
      aoe_n_r <= aoe_nxt;
      doe_n_r <= doe_nxt;
      transfer_complete_r  <= (state_r == CBM_TERM) && !exc_r && !exc_now;
      done_r  <= (state_r == CBM_TERM) && !relock_pending();
      err_r   <= (state_r == CBM_TERM) && (exc_r || exc_now);
      cdone_r <= copro_r && busy && cdn_s;
    end
  end

  function automatic logic relock_pending();
    relock_pending = lock_r && !lock_wr_r && !exc_r && !exc_now;
  endfunction : relock_pending

  assign busy              = (state_r != CBM_IDLE);
  assign rdata             = rdata_r;
  assign done_pulse        = done_r;
  assign error_pulse       = err_r;
  assign copro_done        = cdone_r;
  assign addr_out          = addr_r;
  assign addr_oe_n         = aoe_n_r;
  assign addr_strobe_n     = as_n_r;
  assign virtual_addr_flag = virt_r && !as_n_r;
  assign read_write        = !write_r;
  assign data_strobe_n     = ds_n_r;
  assign data_out          = wdata_r;
  assign data_oe_n         = doe_n_r;
  assign bus_cycle_start   = cyc_r;
  assign transfer_complete = transfer_complete_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cyc_two;
    bus_cycle_start [*2] ##1 !bus_cycle_start;
  endsequence

  AST_CYC_WIDTH: assert property (@(posedge clk) disable iff (reset)
    $rose(bus_cycle_start) |-> s_cyc_two)
    else $error("cycle start width not two");

  AST_AS_IDLE: assert property (@(posedge clk) disable iff (reset)
    (state_r == CBM_IDLE) |-> addr_strobe_n)
    else $error("address strobe low while idle");

  AST_DATA_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (!data_oe_n) |-> !read_write)
    else $error("data driven during read");

  AST_DS_AFTER_DATA: assert property (@(posedge clk)
    disable iff (reset)
    ($fell(data_strobe_n) && !read_write) |-> $past(!data_oe_n))
    else $error("write strobe before data valid");

  AST_SHADOW_ACK: assert property (@(posedge clk) disable iff (reset)
    (state_r == CBM_DATA && shad_s && !rdy_hit_r && !rdy_ok)
      |=> state_r == CBM_DATA)
    else $error("ack taken under shadow");

  AST_ACK_END: assert property (@(posedge clk) disable iff (reset)
    (state_r == CBM_DATA && ack_ok) |=> state_r == CBM_TERM)
    else $error("ack did not end cycle");

  AST_WAIT: assert property (@(posedge clk) disable iff (reset)
    (state_r == CBM_DATA && ack_n_s && !rdy_ok && !rdy_hit_r)
      |=> state_r == CBM_DATA)
    else $error("cycle ended without ack or ready");

  AST_TRANSFER_COMPLETE_EXC: assert property (@(posedge clk) disable iff (reset)
    transfer_complete |-> !$past(exc_r))
    else $error("data ready after exception");

  AST_VIRT_FLOAT: assert property (@(posedge clk) disable iff (reset)
    (virt_r && state_r == CBM_TERM) |-> addr_oe_n)
    else $error("virtual address still driven");

endmodule : cbm_bus_master

`default_nettype wire

// *** tb/cbm_slave_model.sv ***
/*
  Bus slave model for the bus master handshake bench: answers data strobes
  with an acknowledge after a set delay, and also with synchronous ready in ready mode.
  Assumes one clock shared with the master and tb-driven settings.
*/
`timescale 1ns/1ps
`default_nettype none

module cbm_slave_model (
  input  wire logic        clk,
  input  wire logic        data_strobe_n,
  input  wire logic        read_write,
  input  var  int          ack_dly,
  input  wire logic        rdy_mode,
  input  wire logic [31:0] rd_word,
  output logic             async_transfer_ack,
  output logic             sync_ready_in,
  output logic [31:0]      slv_data
);
  int cnt_r;

  initial begin
    cnt_r = 0;
    async_transfer_ack = 1'b1;
    sync_ready_in = 1'b1;
    slv_data = 32'h0;
  end

  // ----------------------------------------------------------------
  // Answer just after each edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    #2;
    cnt_r = data_strobe_n ? 0 : cnt_r + 1;
    async_transfer_ack = !(!data_strobe_n && cnt_r > ack_dly);
    sync_ready_in = !(!data_strobe_n && rdy_mode);
    // Off-window value keeps changing so a stale latch shows up
    if (!data_strobe_n && read_write) begin
      slv_data = rd_word;
    end else begin
      slv_data = ~slv_data;
    end
  end
endmodule : cbm_slave_model

`default_nettype wire

// *** tb/cbm_bus_master_test.sv ***
/*
  Self-checking bench for the bus master handshake block.
  Assumes cbm_pkg is compiled first and the slave model is available.
*/
`timescale 1ns/1ps
`default_nettype none

module cbm_bus_master_test
  import cbm_pkg::*;
;
  logic              clk, reset, req, req_write, req_interlock;
  logic              req_virtual, req_copro, busy, done_pulse, error_pulse;
  logic              copro_done, addr_oe_n, addr_strobe_n, read_write;
  logic              data_strobe_n, data_oe_n, bus_cycle_start;
  logic              transfer_complete, async_transfer_ack, sync_ready_in;
  logic              shadow_bus_hold, fault_in, retry_in, rdy_mode;
  logic              relinquish_retry_req, copro_done_in, virtual_addr_flag;
  logic [ADDR_W-1:0] req_addr, addr_out;
  logic [DATA_W-1:0] req_wdata, rdata, data_out, data_in, slv_data, rd_word;
  int                ack_dly, mismatches, checks, seed, cycles;

  assign data_in = data_oe_n ? slv_data : data_out;

  cbm_bus_master uut (.clk(clk), .reset(reset), .req(req),
    .req_write(req_write), .req_interlock(req_interlock),
    .req_virtual(req_virtual), .req_copro(req_copro), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .rdata(rdata),
    .done_pulse(done_pulse), .error_pulse(error_pulse),
    .copro_done(copro_done), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
    .addr_strobe_n(addr_strobe_n), .virtual_addr_flag(virtual_addr_flag),
    .read_write(read_write), .data_strobe_n(data_strobe_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
    .bus_cycle_start(bus_cycle_start),
    .transfer_complete(transfer_complete),
    .async_transfer_ack(async_transfer_ack), .sync_ready_in(sync_ready_in),
    .shadow_bus_hold(shadow_bus_hold), .fault_in(fault_in),
    .retry_in(retry_in), .relinquish_retry_req(relinquish_retry_req),
    .copro_done_in(copro_done_in));

  cbm_slave_model slave (.clk(clk), .data_strobe_n(data_strobe_n),
    .read_write(read_write), .ack_dly(ack_dly), .rdy_mode(rdy_mode),
    .rd_word(rd_word), .async_transfer_ack(async_transfer_ack),
    .sync_ready_in(sync_ready_in), .slv_data(slv_data));

  always #5 clk = ~clk;

  task end_of_test;
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hang short well beyond the length of all transfers
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // One transaction, watched cycle by cycle
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, il, vir, cp, input logic [31:0] a, wd,
                      input int dly, input logic rdy, input int sh,
                      input logic [1:0] ex);
    int   cyc, hi, rise, as_lo, ack_c, n;
    logic tc, cpd, prev;
    cyc = 0; hi = 0; rise = 0; as_lo = 0; ack_c = 0; n = 0;
    tc = 0; cpd = 0; prev = 0;
    ack_dly = dly;
    rdy_mode = rdy;
    rd_word = $random(seed);
    req = 1; req_write = w; req_interlock = il; req_virtual = vir;
    req_copro = cp; req_addr = a; req_wdata = wd; copro_done_in = 1;
    shadow_bus_hold = sh > 0;
    fault_in = ex == 2'h1; retry_in = ex == 2'h2;
    relinquish_retry_req = ex == 2'h3;
    @(posedge clk);
    #1;
    req = 0;
    repeat (200) begin
      cyc++;
      shadow_bus_hold = cyc < sh;
      if (!async_transfer_ack && ack_c == 0) ack_c = cyc;
      if (bus_cycle_start) hi++;
      if (bus_cycle_start && !prev) rise++;
      prev = bus_cycle_start;
      tc |= transfer_complete;
      cpd |= copro_done;
      as_lo = addr_strobe_n ? 0 : as_lo + 1;
      if (as_lo == 1 || (!addr_strobe_n && !vir)) chk(addr_out, a);
      if (as_lo == 1 || (!addr_strobe_n && !vir)) begin
        chk(32'(addr_oe_n), 32'h0);
      end
      if (!addr_strobe_n) begin
        chk(32'(read_write), 32'(!(w || (il && rise == 2))));
        chk(32'(virtual_addr_flag), 32'(vir));
      end
      if (as_lo >= 3 && vir) chk(32'(addr_oe_n), 32'h1);
      if (!data_strobe_n) chk(32'(data_oe_n), 32'(read_write));
      if (!data_strobe_n && !read_write) chk(data_out, wd);
      if (done_pulse || error_pulse) break;
      @(posedge clk);
      #1;
    end
    chk({done_pulse, error_pulse}, {1'b1, ex != 2'h0});
    chk(32'(hi), 32'(CYCLE_START_LEN) * (il ? 2 : 1));
    chk(32'(rise), il ? 32'h2 : 32'h1);
    chk(32'(tc), 32'(ex == 2'h0));
    chk(32'(cpd), 32'(cp));
    if ((!w || il) && ex == 2'h0) chk(rdata, rd_word);
    if (!rdy && !il && sh == 0 && ex == 2'h0) begin
      chk(32'(cyc > ack_c && cyc <= ack_c + 5), 32'h1);
    end
    if (!rdy && sh > 0) chk(32'(cyc > sh), 32'h1);
    if (rdy && sh == 0) chk(32'(ack_c), 32'h0);
    if (rdy && sh > 0) chk(32'(ack_c > 0 && cyc > ack_c), 32'h1);
    shadow_bus_hold = 0; fault_in = 0; retry_in = 0;
    relinquish_retry_req = 0; copro_done_in = 0;
    while (busy && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : xfer

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; reset = 1; req = 0; req_write = 0; req_interlock = 0;
    req_virtual = 0; req_copro = 0; req_addr = 32'h0; req_wdata = 32'h0;
    shadow_bus_hold = 0; fault_in = 0; retry_in = 0; rdy_mode = 0;
    relinquish_retry_req = 0; copro_done_in = 0; rd_word = 32'h0;
    ack_dly = 0; mismatches = 0; checks = 0; seed = 90; cycles = 0;
    repeat (8) @(posedge clk);
    #1;
    reset = 0;
    repeat (2) begin
      chk({addr_strobe_n, data_strobe_n, addr_oe_n, data_oe_n,
           bus_cycle_start, transfer_complete, busy}, 32'h78);
      @(posedge clk);
      #1;
    end
    xfer(0, 0, 0, 0, 32'h0000_0004, 32'h0, 0, 0, 0, 2'h0);
    xfer(1, 0, 0, 0, 32'hffff_fffc, 32'ha5a5_5a5a, 0, 0, 0, 2'h0);
    xfer(0, 1, 0, 0, 32'h0000_1000, 32'h1234_5678, 1, 0, 0, 2'h0);
    xfer(0, 0, 1, 0, 32'h8000_0010, 32'h0, 3, 0, 0, 2'h0);
    xfer(1, 0, 0, 1, 32'h0000_0020, 32'h0bad_f00d, 2, 0, 0, 2'h0);
    xfer(0, 0, 0, 0, 32'h0000_0040, 32'h0, 12, 1, 0, 2'h0);
    xfer(1, 0, 0, 0, 32'h0000_0044, 32'hc0de_0001, 12, 1, 2, 2'h0);
    xfer(0, 0, 0, 0, 32'h0000_0048, 32'h0, 0, 0, 15, 2'h0);
    for (int e = 1; e < 4; e++) begin
      xfer(e[0], 0, 0, 0, 32'h0000_0100, 32'hdead_0000, 1, 0, 0, e[1:0]);
    end
    // Random mix of reads, writes, virtual and coprocessor accesses
    repeat (12) begin
      xfer($random(seed), 0, $random(seed), $random(seed), $random(seed),
           $random(seed), {$random(seed)} % 6, 0, 0, 2'h0);
    end
    end_of_test();
  end
endmodule : cbm_bus_master_test

`default_nettype wire
